// ===== tlc_pkg.sv
// Functional notes
// [RL1] polarity bit sets signal-detect active level
// [RL2] dejitter loop timing selects recovered reference
// [RL3] plain loop timing replaces multiplier reference
// [RL4] mute receive outputs on signal loss
// [RL5] disable bit forces receive outputs low
// [RL6] lock-detect enable activates oscillator lock circuit
// [RL7] software writes zero to reserved bit one
// [RL8] local loopback routes transmit to receive
// [RL9] serial output stays valid during local loopback
// [RL10] serial remote loopback returns serial input
// [RL11] receive outputs valid in serial remote loopback
// [RL12] local and serial remote loopback may combine
// [RL13] parallel remote loopback feeds transmit fifo path
// [RL14] receive outputs valid in parallel remote loopback
// [RL15] software avoids other loopbacks with parallel remote
// [RL16] software flushes fifo when toggling parallel remote
// [RL17] software holds fifo reset two clock cycles
// [RL18] flush completes 8 to 10 cycles after release
// [RL19] lock flag meaningful only while detect enabled
// [RL20] signal loss flag reads one on loss
// [RL21] unused bits ignore writes, read zero
package tlc_pkg;

    localparam logic [7:0]  IDX_LINE_CFG    = 8'h04;
    localparam logic [7:0]  IDX_LB_DIAG     = 8'h05;
    localparam logic [7:0]  IDX_FIFO_FLUSH  = 8'h06;
    localparam logic [7:0]  IDX_LINE_STATUS = 8'h07;
    localparam int          ADDR_W          = 12;

    // line config bit positions
    localparam int          CFG_POLARITY    = 6;
    localparam int          CFG_LT_DEJIT    = 5;
    localparam int          CFG_LT_PLAIN    = 4;
    localparam int          CFG_MUTE_LOSS   = 3;
    localparam int          CFG_RX_DISABLE  = 2;
    localparam int          CFG_RSVD_RW     = 1;
    localparam int          CFG_LOCK_EN     = 0;
    localparam logic [7:0]  CFG_RW_MASK     = 8'h7f;
    localparam logic [7:0]  CFG_RESET       = 8'h00;

    // diag bit positions
    localparam int          DIAG_LOCAL_LB   = 2;
    localparam int          DIAG_SER_REM_LB = 1;
    localparam int          DIAG_PAR_REM_LB = 0;
    localparam logic [7:0]  DIAG_RW_MASK    = 8'h07;
    localparam logic [7:0]  DIAG_RESET      = 8'h00;

    // flush / status bit positions
    localparam int          FL_MANUAL_RST   = 0;
    localparam int          FL_BUSY         = 1;
    localparam int          ST_LOCK         = 0;
    localparam int          ST_LOSS         = 1;

    localparam logic [3:0]  FLUSH_TICKS     = 4'h8;
    localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    typedef struct packed {
        logic       polarity;
        logic       lt_dejit;
        logic       lt_plain;
        logic       mute_loss;
        logic       rx_disable;
        logic       rsvd_rw;
        logic       lock_en;
    } tlc_cfg_s;

    typedef struct packed {
        logic       local_lb;
        logic       ser_rem_lb;
        logic       par_rem_lb;
    } tlc_diag_s;

    typedef enum logic [1:0] {
        FL_IDLE,
        FL_HOLD,
        FL_DRAIN
    } tlc_flush_e;

endpackage

// ===== tlc_loopback_cfg.sv
`timescale 1ns/1ps
module tlc_loopback_cfg
    import tlc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               ext_signal_detect_in,
    input  wire logic               osc_lock_raw,
    input  wire logic               tx_pclk_tick,
    input  wire logic [3:0]         rx_serial_to_parallel_conv_data,
    input  wire logic [3:0]         tx_par_data_in,
    input  wire logic               rx_serial_in,
    input  wire logic               tx_parallel_to_serial_conv_serial,
    output logic [3:0]              rx_parallel_data_out,
    output logic [3:0]              tx_fifo_data,
    output logic                    tx_serial_out,
    output logic                    dejit_ref_recovered,
    output logic                    cmu_ref_recovered,
    output logic                    osc_lock_detect_en,
    output logic                    tx_fifo_reset
);

    tlc_cfg_s           cfg_ff;
    tlc_diag_s          diag_ff;
    logic               fifo_rst_bit_ff;
    tlc_flush_e         flush_state_ff;
    logic [3:0]         flush_cnt_ff;
    logic               signal_loss_flag_ff;
    logic               osc_lock_flag_ff;
    logic [31:0]        prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;
    logic [3:0]         rx_out_ff;
    logic [3:0]         tx_fifo_ff;
    logic               tx_ser_ff;
    logic               dejit_ff;
    logic               cmu_ff;
    logic               lock_en_ff;
    logic               fifo_reset_ff;

    logic [7:0]         reg_idx;
    logic               idx_ok;
    logic               acc_phase;
    logic               wr_done;
    logic [7:0]         rd_byte;
    logic               sd_active;

    assign reg_idx   = paddr[9:2];
    assign idx_ok    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0) &&
                       (reg_idx >= IDX_LINE_CFG) && (reg_idx <= IDX_LINE_STATUS);
    assign acc_phase = psel && penable;
    assign wr_done   = acc_phase && pready_ff && pwrite && idx_ok;

    // signal detect polarity: 0 active low, 1 active high
    assign sd_active = cfg_ff.polarity ? ext_signal_detect_in : !ext_signal_detect_in; // [RL1]

    // read mux, unused bits zero
    always_comb begin
        rd_byte = 8'h00;
        case (reg_idx)
            IDX_LINE_CFG: begin
                rd_byte = {1'b0, cfg_ff} & CFG_RW_MASK; // [RL21]
            end
            IDX_LB_DIAG: begin
                rd_byte = {5'b00000, diag_ff} & DIAG_RW_MASK; // [RL21]
            end
            IDX_FIFO_FLUSH: begin
                rd_byte[FL_MANUAL_RST] = fifo_rst_bit_ff;
                rd_byte[FL_BUSY]       = (flush_state_ff != FL_IDLE);
            end
            IDX_LINE_STATUS: begin
                rd_byte[ST_LOCK] = osc_lock_flag_ff;
                rd_byte[ST_LOSS] = signal_loss_flag_ff;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // apb handshake, one wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= WORD_ZERO;
        end else if (acc_phase && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !idx_ok;
            prdata_ff  <= (!pwrite && idx_ok) ? {24'h00_0000, rd_byte} : WORD_ZERO;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= WORD_ZERO;
        end
    end

    // line config register, reserved bit one stored as written
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= tlc_cfg_s'(CFG_RESET[6:0]);
        end else if (wr_done && reg_idx == IDX_LINE_CFG) begin
            cfg_ff <= tlc_cfg_s'(pwdata[6:0]); // [RL21] [RL7]
        end
    end

    // loopback diag register, local and serial remote may coexist
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_ff <= tlc_diag_s'(DIAG_RESET[2:0]);
        end else if (wr_done && reg_idx == IDX_LB_DIAG) begin
            diag_ff <= tlc_diag_s'(pwdata[2:0]); // [RL12] [RL15]
        end
    end

    // manual fifo reset bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_rst_bit_ff <= 1'b0;
        end else if (wr_done && reg_idx == IDX_FIFO_FLUSH) begin
            fifo_rst_bit_ff <= pwdata[FL_MANUAL_RST]; // [RL16]
        end
    end

    // flush sequencer counting tx parallel clock ticks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flush_state_ff <= FL_IDLE;
            flush_cnt_ff   <= NIBBLE_ZERO;
        end else begin
            case (flush_state_ff)
                FL_IDLE: begin
                    if (fifo_rst_bit_ff) begin
                        flush_state_ff <= FL_HOLD; // [RL17]
                    end
                end
                FL_HOLD: begin
                    flush_cnt_ff <= NIBBLE_ZERO;
                    if (!fifo_rst_bit_ff) begin
                        flush_state_ff <= FL_DRAIN;
                    end
                end
                FL_DRAIN: begin
                    if (fifo_rst_bit_ff) begin
                        flush_state_ff <= FL_HOLD;
                    end else if (tx_pclk_tick) begin
                        if (flush_cnt_ff == FLUSH_TICKS - 4'h1) begin
                            flush_state_ff <= FL_IDLE; // [RL18]
                            flush_cnt_ff   <= NIBBLE_ZERO;
                        end else begin
                            flush_cnt_ff <= flush_cnt_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    flush_state_ff <= FL_IDLE;
                    flush_cnt_ff   <= NIBBLE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_reset_ff <= 1'b0;
        end else begin
            fifo_reset_ff <= fifo_rst_bit_ff || (flush_state_ff != FL_IDLE); // [RL18]
        end
    end

    // status flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            signal_loss_flag_ff <= 1'b0;
            osc_lock_flag_ff    <= 1'b0;
        end else begin
            signal_loss_flag_ff <= !sd_active; // [RL20]
            osc_lock_flag_ff    <= cfg_ff.lock_en && osc_lock_raw; // [RL19]
        end
    end

    // receive parallel output path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_out_ff <= NIBBLE_ZERO;
        end else if (cfg_ff.rx_disable) begin
            rx_out_ff <= NIBBLE_ZERO; // [RL5]
        end else if (cfg_ff.mute_loss && !sd_active) begin
            rx_out_ff <= NIBBLE_ZERO; // [RL4]
        end else if (diag_ff.local_lb) begin
            rx_out_ff <= tx_par_data_in; // [RL8]
        end else begin
            rx_out_ff <= rx_serial_to_parallel_conv_data; // [RL11] [RL14]
        end
    end

    // transmit fifo input, receive data in parallel remote loopback
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_fifo_ff <= NIBBLE_ZERO;
        end else if (diag_ff.par_rem_lb) begin
            tx_fifo_ff <= rx_serial_to_parallel_conv_data; // [RL13]
        end else begin
            tx_fifo_ff <= tx_par_data_in;
        end
    end

    // serial transmit output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ser_ff <= 1'b0;
        end else if (diag_ff.ser_rem_lb) begin
            tx_ser_ff <= rx_serial_in; // [RL10]
        end else begin
            tx_ser_ff <= tx_parallel_to_serial_conv_serial; // [RL9]
        end
    end

    // clock reference selects and lock detect enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dejit_ff   <= 1'b0;
            cmu_ff     <= 1'b0;
            lock_en_ff <= 1'b0;
        end else begin
            dejit_ff   <= cfg_ff.lt_dejit; // [RL2]
            cmu_ff     <= cfg_ff.lt_plain; // [RL3]
            lock_en_ff <= cfg_ff.lock_en; // [RL6]
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign rx_parallel_data_out = rx_out_ff;
    assign tx_fifo_data         = tx_fifo_ff;
    assign tx_serial_out        = tx_ser_ff;
    assign dejit_ref_recovered  = dejit_ff;
    assign cmu_ref_recovered    = cmu_ff;
    assign osc_lock_detect_en   = lock_en_ff;
    assign tx_fifo_reset        = fifo_reset_ff;

endmodule

// ===== tlc_loopback_monitor.sv
`timescale 1ns/1ps
module tlc_loopback_monitor
    import tlc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        ext_signal_detect_in,
    input wire logic [3:0]  rx_serial_to_parallel_conv_data,
    input wire logic [3:0]  tx_par_data_in,
    input wire logic        rx_serial_in,
    input wire logic        tx_parallel_to_serial_conv_serial,
    input wire logic [3:0]  rx_parallel_data_out,
    input wire logic [3:0]  tx_fifo_data,
    input wire logic        tx_serial_out,
    input wire logic        dejit_ref_recovered,
    input wire logic        cmu_ref_recovered,
    input wire logic        osc_lock_detect_en
);
    logic [6:0] cfg_ff;
    logic [2:0] diag_ff;
    logic       wr;
    logic       rd;
    assign wr = psel & penable & pready & pwrite;
    assign rd = psel & penable & pready & !pwrite;
    // mirror of the control registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff  <= 7'h00;
            diag_ff <= 3'h0;
        end else if (wr && paddr == 12'h010) begin
            cfg_ff  <= pwdata[6:0];
        end else if (wr && paddr == 12'h014) begin
            diag_ff <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_lock_copy: assert property ($past(rst_b) |-> osc_lock_detect_en == $past(cfg_ff[0]))
        else $error("lock enable copy wrong");
    chk_dejit_copy: assert property ($past(rst_b) |-> dejit_ref_recovered == $past(cfg_ff[5]))
        else $error("dejitter reference select wrong");
    chk_cmu_copy: assert property ($past(rst_b) |-> cmu_ref_recovered == $past(cfg_ff[4]))
        else $error("multiplier reference select wrong");
    chk_rx_path: assert property ($past(rst_b) |-> rx_parallel_data_out == $past(
        (cfg_ff[2] | cfg_ff[3] & (ext_signal_detect_in ^ cfg_ff[6])) ? 4'h0 :
        diag_ff[2] ? tx_par_data_in : rx_serial_to_parallel_conv_data))
        else $error("receive output wrong");
    chk_serial_out: assert property ($past(rst_b) |->
        tx_serial_out == $past(diag_ff[1] ? rx_serial_in : tx_parallel_to_serial_conv_serial))
        else $error("serial output wrong");
    chk_fifo_path: assert property ($past(rst_b) |->
        tx_fifo_data == $past(diag_ff[0] ? rx_serial_to_parallel_conv_data : tx_par_data_in))
        else $error("fifo data wrong");
    chk_unused_zero: assert property (rd |-> prdata[31:8] == 24'h00_0000 &&
        (paddr != 12'h010 || !prdata[7]) && (paddr != 12'h014 || prdata[7:3] == 5'h00))
        else $error("unused read bits not zero");
    chk_diag_back: assert property (rd && paddr == 12'h014 |-> prdata[2:0] == diag_ff)
        else $error("diag read back wrong");
endmodule

bind tlc_loopback_cfg tlc_loopback_monitor mon_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .ext_signal_detect_in, .rx_serial_to_parallel_conv_data, .tx_par_data_in, .rx_serial_in,
    .tx_parallel_to_serial_conv_serial, .rx_parallel_data_out, .tx_fifo_data, .tx_serial_out, .dejit_ref_recovered,
    .cmu_ref_recovered, .osc_lock_detect_en);

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb
    import tlc_pkg::*;
;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, t;
    logic        ext_signal_detect_in, osc_lock_raw, tx_pclk_tick, rx_serial_in, tx_parallel_to_serial_conv_serial;
    logic [3:0]  rx_serial_to_parallel_conv_data, tx_par_data_in, rx_parallel_data_out, tx_fifo_data;
    logic        tx_serial_out, dejit_ref_recovered, cmu_ref_recovered, osc_lock_detect_en, tx_fifo_reset;
    int          fail_count, check_count, cyc, n;
    logic [31:0] tbl [8];

    tlc_loopback_cfg dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_signal_detect_in, .osc_lock_raw, .tx_pclk_tick, .rx_serial_to_parallel_conv_data, .tx_par_data_in,
        .rx_serial_in, .tx_parallel_to_serial_conv_serial, .rx_parallel_data_out, .tx_fifo_data, .tx_serial_out,
        .dejit_ref_recovered, .cmu_ref_recovered, .osc_lock_detect_en, .tx_fifo_reset);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // table: cfg, diag, detect, rx out, serial out, fifo data
    task automatic setup(input logic [31:0] v);
        apb(1'b1, 12'h010, {24'h00_0000, v[31:24]});
        apb(1'b1, 12'h014, {28'h000_0000, v[23:20]});
        ext_signal_detect_in <= v[16];
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, ext_signal_detect_in, tx_parallel_to_serial_conv_serial} = '0;
        {osc_lock_raw, tx_pclk_tick, rx_serial_in} = 3'h7;
        rx_serial_to_parallel_conv_data   = 4'h5;
        tx_par_data_in = 4'hA;
        tbl = '{32'h0400_00A0, 32'h0801_00A0, 32'h0800_50A0, 32'h4800_00A0,
                32'h0040_A0A0, 32'h0060_A1A0, 32'h0020_51A0, 32'h0010_5050};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        `CHK("cfg reset", 32'h0000_0000, rd)
        apb(1'b0, 12'h014, 32'h0);
        `CHK("diag reset", 32'h0000_0000, rd)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        // reserved bit one left at zero
        apb(1'b1, 12'h010, 32'h0000_00FD);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("cfg rw", 32'h0000_007D, rd)
        apb(1'b1, 12'h014, 32'h0000_00FF);
        apb(1'b0, 12'h014, 32'h0);
        `CHK("diag rw", 32'h0000_0007, rd)
        `CHK("dejit ref", 1'b1, dejit_ref_recovered)
        `CHK("cmu ref", 1'b1, cmu_ref_recovered)
        `CHK("lock en", 1'b1, osc_lock_detect_en)
        apb(1'b0, 12'h01C, 32'h0);
        `CHK("status", 32'h0000_0003, rd)
        for (int i = 0; i < 8; i++) begin
            t = tbl[i];
            setup(t);
            `CHK("rx out", t[15:12], rx_parallel_data_out)
            `CHK("serial out", t[8], tx_serial_out)
            `CHK("fifo data", t[7:4], tx_fifo_data)
            apb(1'b0, 12'h01C, 32'h0);
            `CHK("loss flag", {30'h0000_0000, t[16] ^ t[30], 1'b0}, rd)
        end
        apb(1'b1, 12'h018, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK("fifo reset", 1'b1, tx_fifo_reset)
        apb(1'b1, 12'h018, 32'h0);
        n = 0;
        while (tx_fifo_reset === 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        `CHK("flush length", 1'b1, n >= 9 && n <= 12)
        finish_test();
    end
endmodule
